// ==== verilog/three_wire_eeprom_master.sv ====
`timescale 1ns/1ps
`include "eeprom_defs.svh"
// What this block does
// - Data changes on falling clock, stable across the rising edge where EEPROM samples.
// - Every transfer is exactly eight bits; frames are byte sequences.
// - Bytes go out and come in most significant bit first.
// - Serial clock runs at 500 kbps from the core clock.
// - Serial clock rests low when idle and before the first transfer.
// - Serial data output rests low when idle and before the first transfer.
// - A transfer-end pulse follows each byte; the next byte of the same frame starts from it.
// - Bytes start only on the internal trigger, never from outside events.
// - Every byte sent also captures one byte from the EEPROM.
// - Link is half-duplex; command bits ignore input, read bits send ones.
// - Write-enable is sent before erase-all and any write.
// - After erase-all, drop select, wait, sample status until high.
// - Each write is polled likewise; 64 writes cover addresses 0 to 63.
// - Write frame: start bit, two-bit opcode, six-bit address, sixteen data bits.
// - Write bytes: 01h, opcode 01 plus address, data high, data low.
// - Read frame: start, opcode, address, zero dummy, sixteen filler ones.
// - Read bytes: 02h, one-address-zero, FFh, FFh; last two bytes hold the word.
// - 64 reads in address order, each word stored and compared.
// - Reads sample on the rising edge, relying on the EEPROM output delay.
// - Optionally sample on the falling edge from the third read byte.
// - Select is active high.
// - Polling holds select low at least 250 ns, then raises it and reads status.
// - At least 50 ns from select high to the first clock edge.
module three_wire_eeprom_master
   import eeprom_pkg::*;
#(
   parameter int HALF_BIT = `HALF_BIT_CYC,
   parameter int SETUP = `SEL_SETUP_CYC,
   parameter int POLL_LOW = `POLL_LOW_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Control
   input wire logic run_start,
   input wire logic rx_type2_en,
   input wire logic [15:0] data_seed,
   // Readback port
   input wire logic [5:0] rd_addr,
   output logic [15:0] rd_word_r,
   // Status
   output status_s status_r,
   output logic transfer_end_irq,
   // Link
   output link_s link_r,
   input wire logic serial_data_in
);
   byte_state_e bstate_r;
   seq_state_e sstate_r;
   cmd_e cmd_r;
   logic [7:0] hcnt_r;
   logic [2:0] bcnt_r;
   logic [7:0] tx_r;
   logic [7:0] rx_r;
   logic [31:0] frame_r;
   logic [1:0] bidx_r;
   logic byte_go_r;
   logic ready_r;
   logic [7:0] wcnt_r;
   logic [5:0] addr_r;
   logic [15:0] rword_r;
   logic [15:0] mem_r [0:`WORD_COUNT-1];
   // Pins kept as separate flops so each has a single driving process
   logic sel_r;
   logic sck_r;
   logic sdo_r;
   logic fall_din_r;

   assign link_r = {sel_r, sck_r, sdo_r};

   wire half_end = (hcnt_r == 8'(HALF_BIT - 1));
   wire last_bit = (bcnt_r == 3'h7);
   wire [15:0] wdata = data_seed + {10'h0, addr_r};
   // Falling-edge sampling only where the EEPROM is actually driving data
   wire late = rx_type2_en && (cmd_r == C_READ) && (bidx_r >= `FIRST_DATA_BYTE);
   // Fall sample is half a bit ahead of the rise, before the output moves again
   wire rx_bit = late ? fall_din_r : serial_data_in;
   wire [7:0] rx_shift = {rx_r[6:0], rx_bit};
   wire [31:0] frame_build =
      (cmd_r == C_ENABLE) ? `FRAME_ENABLE :
      (cmd_r == C_ERASE) ? `FRAME_ERASE :
      (cmd_r == C_WRITE) ? {`WRITE_LEAD, `WRITE_OP, addr_r, wdata} :
      {`READ_LEAD, `READ_OP_TAIL, addr_r, 1'b0, `READ_FILL};
   wire polling = (cmd_r == C_ERASE) || (cmd_r == C_WRITE);
   wire wait_done = (wcnt_r == 8'(POLL_LOW - 1));
   wire setup_done = (wcnt_r == 8'(SETUP - 1));

   // Byte shifter
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bstate_r <= B_IDLE;
         hcnt_r <= 8'h0;
         bcnt_r <= 3'h0;
         tx_r <= 8'h0;
         rx_r <= 8'h0;
         transfer_end_irq <= 1'b0;
         fall_din_r <= 1'b0;
         sck_r <= 1'b0;
         sdo_r <= 1'b0;
      end else begin
         transfer_end_irq <= 1'b0;
         unique case (bstate_r)
            B_IDLE: begin
               if (byte_go_r) begin
                  tx_r <= frame_r[31:24];
                  sdo_r <= frame_r[31];
                  hcnt_r <= 8'h0;
                  bcnt_r <= 3'h0;
                  bstate_r <= B_LOW;
               end
            end
            B_LOW: begin
               hcnt_r <= half_end ? 8'h0 : hcnt_r + 8'h1;
               if (half_end) begin
                  sck_r <= 1'b1;
                  rx_r <= rx_shift;
                  bstate_r <= B_HIGH;
               end
            end
            B_HIGH: begin
               hcnt_r <= half_end ? 8'h0 : hcnt_r + 8'h1;
               if (half_end) begin
                  sck_r <= 1'b0;
                  fall_din_r <= serial_data_in;
                  if (last_bit) begin
                     transfer_end_irq <= 1'b1;
                     sdo_r <= 1'b0;
                     bstate_r <= B_IDLE;
                  end else begin
                     bcnt_r <= bcnt_r + 3'h1;
                     tx_r <= {tx_r[6:0], 1'b0};
                     sdo_r <= tx_r[6];
                     bstate_r <= B_LOW;
                  end
               end
            end
            default: bstate_r <= B_IDLE;
         endcase
      end
   end

   // Command sequencer
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sstate_r <= S_IDLE;
         cmd_r <= C_ENABLE;
         frame_r <= 32'h0;
         bidx_r <= 2'h0;
         byte_go_r <= 1'b0;
         ready_r <= 1'b0;
         wcnt_r <= 8'h0;
         addr_r <= 6'h0;
         rword_r <= 16'h0;
         sel_r <= 1'b0;
         status_r <= '0;
      end else begin
         byte_go_r <= 1'b0;
         unique case (sstate_r)
            S_IDLE: begin
               if (run_start) begin
                  cmd_r <= C_ENABLE;
                  addr_r <= 6'h0;
                  status_r <= '0;
                  status_r.busy <= 1'b1;
                  sstate_r <= S_LOAD;
               end
            end
            S_LOAD: begin
               frame_r <= frame_build;
               sel_r <= 1'b1;
               wcnt_r <= 8'h0;
               bidx_r <= 2'h0;
               sstate_r <= S_CSUP;
            end
            S_CSUP: begin
               wcnt_r <= wcnt_r + 8'h1;
               if (setup_done) begin
                  byte_go_r <= 1'b1;
                  sstate_r <= S_XFER;
               end
            end
            S_XFER: begin
               if (byte_go_r) begin
                  frame_r <= {frame_r[23:0], 8'h0};
               end
               if (transfer_end_irq) begin
                  if (cmd_r == C_READ && bidx_r >= `FIRST_DATA_BYTE) begin
                     rword_r <= {rword_r[7:0], rx_r};
                  end
                  if (bidx_r == 2'(`FRAME_BYTES - 1)) begin
                     sel_r <= 1'b0;
                     wcnt_r <= 8'h0;
                     ready_r <= 1'b0;
                     sstate_r <= S_PLOW;
                  end else begin
                     bidx_r <= bidx_r + 2'h1;
                     byte_go_r <= 1'b1;
                  end
               end
            end
            S_PLOW: begin
               wcnt_r <= wcnt_r + 8'h1;
               if (wait_done) begin
                  wcnt_r <= 8'h0;
                  if (polling && !ready_r) begin
                     sel_r <= 1'b1;
                     sstate_r <= S_PUP;
                  end else begin
                     sstate_r <= S_ADV;
                  end
               end
            end
            S_PUP: begin
               wcnt_r <= wcnt_r + 8'h1;
               if (setup_done) begin
                  ready_r <= serial_data_in;
                  sel_r <= 1'b0;
                  wcnt_r <= 8'h0;
                  sstate_r <= S_PLOW;
               end
            end
            S_ADV: begin
               sstate_r <= S_LOAD;
               unique case (cmd_r)
                  C_ENABLE: cmd_r <= C_ERASE;
                  C_ERASE: cmd_r <= C_WRITE;
                  C_WRITE: begin
                     addr_r <= addr_r + 6'h1;
                     if (addr_r == `LAST_ADDR) begin
                        cmd_r <= C_READ;
                     end
                  end
                  C_READ: begin
                     addr_r <= addr_r + 6'h1;
                     if (rword_r != wdata) begin
                        status_r.mismatches <= status_r.mismatches + 7'h1;
                     end
                     if (addr_r == `LAST_ADDR) begin
                        sstate_r <= S_DONE;
                     end
                  end
               endcase
            end
            S_DONE: begin
               status_r.busy <= 1'b0;
               status_r.done <= 1'b1;
               sstate_r <= S_IDLE;
            end
         endcase
      end
   end

   // Readback store; no reset so it maps to RAM
   always_ff @(posedge core_clk) begin
      if (sstate_r == S_ADV && cmd_r == C_READ) begin
         mem_r[addr_r] <= rword_r;
      end
      rd_word_r <= mem_r[rd_addr];
   end

   // Checking helpers
   logic [7:0] hi_cnt_r;
   logic [3:0] rise_cnt_r;
   logic [7:0] low_cnt_r;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         hi_cnt_r <= 8'h0;
         rise_cnt_r <= 4'h0;
         low_cnt_r <= 8'hff;
      end else begin
         hi_cnt_r <= link_r.serial_clock_out ? hi_cnt_r + 8'h1 : 8'h0;
         if (byte_go_r) begin
            rise_cnt_r <= 4'h0;
         end else if (link_r.serial_clock_out && hcnt_r == 8'h0 && bstate_r == B_HIGH) begin
            rise_cnt_r <= rise_cnt_r + 4'h1;
         end
         if (link_r.select_port_pin) begin
            low_cnt_r <= 8'h0;
         end else if (low_cnt_r != 8'hff) begin
            low_cnt_r <= low_cnt_r + 8'h1;
         end
      end
   end

   AST_SCK_IDLE_LOW: assert property (@(posedge core_clk) disable iff (!resetn)
      bstate_r == B_IDLE |-> !link_r.serial_clock_out) else $error("clock not low while idle");
   AST_SDO_IDLE_LOW: assert property (@(posedge core_clk) disable iff (!resetn)
      bstate_r == B_IDLE |-> !link_r.serial_data_out) else $error("data not low while idle");
   AST_HALF_BIT: assert property (@(posedge core_clk) disable iff (!resetn)
      $fell(link_r.serial_clock_out) |-> hi_cnt_r == 8'(HALF_BIT)) else $error("bad clock high time");
   AST_EIGHT_BITS: assert property (@(posedge core_clk) disable iff (!resetn)
      transfer_end_irq |-> rise_cnt_r == 4'h8) else $error("byte not eight clocks");
   AST_IRQ_PULSE: assert property (@(posedge core_clk) disable iff (!resetn)
      transfer_end_irq |=> !transfer_end_irq) else $error("end pulse too long");
   AST_SDO_STABLE: assert property (@(posedge core_clk) disable iff (!resetn)
      $rose(link_r.serial_clock_out) |-> $stable(link_r.serial_data_out)) else $error("data moved at rise");
   AST_MSB_FIRST: assert property (@(posedge core_clk) disable iff (!resetn)
      bstate_r == B_IDLE && byte_go_r |=> link_r.serial_data_out == tx_r[7]) else $error("msb not first");
   AST_CS_SETUP: assert property (@(posedge core_clk) disable iff (!resetn)
      $rose(link_r.select_port_pin) |-> !link_r.serial_clock_out [*5]) else $error("clock too soon");
   AST_CS_FRAME: assert property (@(posedge core_clk) disable iff (!resetn)
      bstate_r != B_IDLE |-> link_r.select_port_pin) else $error("select low in byte");
   AST_POLL_LOW: assert property (@(posedge core_clk) disable iff (!resetn)
      $rose(link_r.select_port_pin) |-> $past(low_cnt_r) >= 8'(POLL_LOW - 1)) else $error("select low too short");
   AST_SW_START: assert property (@(posedge core_clk) disable iff (!resetn)
      $past(bstate_r) == B_IDLE && bstate_r == B_LOW |-> $past(byte_go_r)) else $error("untriggered byte");
endmodule

// ==== verilog/eeprom_defs.svh ====
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH
// Timing base
`define CLK_PERIOD_NS 10
`define BIT_RATE_BPS 500000
`define HALF_BIT_NS (1000000000 / `BIT_RATE_BPS / 2)
`define HALF_BIT_CYC (`HALF_BIT_NS / `CLK_PERIOD_NS)
`define SEL_SETUP_NS 50
`define SEL_SETUP_CYC ((`SEL_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POLL_LOW_NS 250
`define POLL_LOW_CYC ((`POLL_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Frame layout
`define BYTE_BITS 8
`define FRAME_BYTES 4
`define WORD_COUNT 64
`define LAST_ADDR 6'h3f
`define FRAME_ENABLE 32'h0000_0130
`define FRAME_ERASE 32'h0000_0120
`define WRITE_LEAD 8'h01
`define WRITE_OP 2'b01
`define READ_LEAD 8'h02
`define READ_OP_TAIL 1'b1
`define READ_FILL 16'hffff
`define FIRST_DATA_BYTE 2'h2
`endif

// ==== verilog/eeprom_pkg.sv ====
package eeprom_pkg;
   typedef enum logic [1:0] {
      B_IDLE = 2'b00,
      B_LOW = 2'b01,
      B_HIGH = 2'b10
   } byte_state_e;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_LOAD = 3'b001,
      S_CSUP = 3'b010,
      S_XFER = 3'b011,
      S_PLOW = 3'b100,
      S_PUP = 3'b101,
      S_ADV = 3'b110,
      S_DONE = 3'b111
   } seq_state_e;
   typedef enum logic [1:0] {
      C_ENABLE = 2'b00,
      C_ERASE = 2'b01,
      C_WRITE = 2'b10,
      C_READ = 2'b11
   } cmd_e;
   typedef struct packed {
      logic select_port_pin;
      logic serial_clock_out;
      logic serial_data_out;
   } link_s;
   typedef struct packed {
      logic busy;
      logic done;
      logic [6:0] mismatches;
   } status_s;
endpackage

// ==== testbench/eeprom_model.sv ====
`timescale 1ns/1ps
`include "eeprom_defs.svh"
module eeprom_model
   import eeprom_pkg::*;
#(
   parameter int BIT_NS = 80,
   parameter int BUSY_POLLS = 2
) (
   // Pins
   input wire logic core_clk,
   input wire link_s link,
   output logic data_out,
   // Bench hooks
   input wire logic [6:0] flip_addr,
   output int writes,
   output int reads,
   output int bad
);
   logic [15:0] mem [0:63];
   logic [31:0] sh;
   logic [15:0] word;
   logic wen, erased, drv, dz, rd;
   int nbit, busy;
   realtime t_sel, t_fall, t_rise;
   initial begin
      {wen, erased, drv, dz, rd} = '0;
      {nbit, busy, writes, reads, bad} = '0;
      t_sel = 0.0;
      t_fall = -1000.0;
      t_rise = 0.0;
   end
   // Released line toggles, so a stale bit cannot pass for data
   always @(posedge core_clk) if (!link.select_port_pin) dz <= ~dz;
   assign data_out = link.select_port_pin ? drv : dz;
   always @(posedge link.select_port_pin) begin
      if ($realtime - t_fall < 250.0) bad++;
      t_sel = $realtime;
      nbit = 0;
      rd = 1'b0;
      drv = (busy == 0);
      if (busy > 0) busy--;
   end
   always @(negedge link.select_port_pin) begin
      t_fall = $realtime;
      if (nbit == 32) begin
         if (sh == `FRAME_ENABLE) wen = 1'b1;
         else if (sh == `FRAME_ERASE && wen) begin
            erased = 1'b1;
            busy = BUSY_POLLS;
         end else if (sh[31:22] == {`WRITE_LEAD, `WRITE_OP} && wen && erased) begin
            if (sh[21:16] != writes[5:0]) bad++;
            mem[sh[21:16]] = sh[15:0];
            writes++;
            busy = BUSY_POLLS;
         end else if (rd) reads++;
         else bad++;
      end else if (nbit != 0) bad++;
   end
   // Data may only move while the clock is low
   always @(link.serial_data_out) if (link.serial_clock_out) bad++;
   always @(posedge link.serial_clock_out) begin
      if (!link.select_port_pin) bad++;
      if (nbit == 0 && $realtime - t_sel < 50.0) bad++;
      if (nbit % 8 != 0 && $realtime - t_rise != BIT_NS) bad++;
      if (rd && nbit >= 16 && link.serial_data_out !== 1'b1) bad++;
      t_rise = $realtime;
      sh = {sh[30:0], link.serial_data_out};
      nbit++;
      if (nbit == 15) begin
         rd = (sh[14:7] == `READ_LEAD);
         if (rd && sh[5:0] != reads[5:0]) bad++;
         word = mem[sh[5:0]] ^ {15'h0000, flip_addr == {1'b0, sh[5:0]}};
      end
      // Output delay well inside the half bit
      #15;
      if (rd && nbit >= 15 && nbit <= 31) drv = (nbit == 15) ? 1'b0 : word[31 - nbit];
      else drv = ~drv;
   end
endmodule

// ==== testbench/three_wire_eeprom_master_bench.sv ====
`timescale 1ns/1ps
module three_wire_eeprom_master_bench;
   import eeprom_pkg::*;
   localparam int HB = 4;
   logic core_clk, resetn, run_start, rx_type2_en, serial_data_in, transfer_end_irq;
   logic [15:0] data_seed, rd_word_r;
   logic [5:0] rd_addr;
   logic [6:0] flip_addr;
   status_s status_r;
   link_s link_r;
   int writes, reads, bad;
   int irqs = 0;
   int fails = 0;
   int check_count = 0;
   three_wire_eeprom_master #(.HALF_BIT(HB), .SETUP(5), .POLL_LOW(25)) u_three_wire_eeprom_master (
      .core_clk(core_clk), .resetn(resetn), .run_start(run_start), .rx_type2_en(rx_type2_en),
      .data_seed(data_seed), .rd_addr(rd_addr), .rd_word_r(rd_word_r), .status_r(status_r),
      .transfer_end_irq(transfer_end_irq), .link_r(link_r), .serial_data_in(serial_data_in));
   eeprom_model #(.BIT_NS(HB * 20), .BUSY_POLLS(2)) u_eeprom_model (
      .core_clk(core_clk), .link(link_r), .data_out(serial_data_in), .flip_addr(flip_addr),
      .writes(writes), .reads(reads), .bad(bad));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (transfer_end_irq === 1'b1) irqs <= irqs + 1;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Nothing may start without a trigger
   task automatic test_idle();
      repeat (40) @(posedge core_clk);
      #1;
      check(link_r, 3'b000, "idle pins");
      check(irqs, 0, "byte without trigger");
      check(status_r, 9'h000, "idle status");
      $display("test_idle done");
   endtask
   // Whole sequence; optional bad word and a refused second trigger
   task automatic test_run(input logic [6:0] flip, input logic [6:0] exp_mis, input logic retrig);
      int i0, w0, r0, n;
      i0 = irqs;
      w0 = writes;
      r0 = reads;
      flip_addr <= flip;
      run_start <= 1'b1;
      @(posedge core_clk);
      run_start <= 1'b0;
      @(posedge core_clk);
      #1;
      check(status_r.busy, 1'b1, "busy after start");
      check(status_r.done, 1'b0, "done cleared");
      if (retrig) begin
         repeat (3000) @(posedge core_clk);
         run_start <= 1'b1;
         @(posedge core_clk);
         run_start <= 1'b0;
      end
      n = 0;
      while (status_r.done !== 1'b1 && n < 60000) begin
         @(posedge core_clk);
         n++;
      end
      if (n == 60000) begin
         fails++;
         $display("MISMATCH t=%0t sequence never finished", $time);
         give_verdict();
      end
      #1;
      check(status_r.busy, 1'b0, "busy at end");
      check(irqs - i0, 520, "byte count");
      check(writes - w0, 64, "accepted writes");
      check(reads - r0, 64, "read frames");
      check(bad, 0, "link protocol");
      check(status_r.mismatches, exp_mis, "compare count");
      for (int a = 0; a < 64; a++) begin
         rd_addr <= a[5:0];
         @(posedge core_clk);
         @(posedge core_clk);
         #1;
         check(rd_word_r, 16'(data_seed + a[15:0]) ^ {15'h0000, flip == a[6:0]}, "stored word");
      end
      $display("test_run done");
   endtask
   initial begin
      resetn = 1'b0;
      run_start = 1'b0;
      rx_type2_en = 1'b0;
      data_seed = 16'h1234;
      rd_addr = 6'h00;
      flip_addr = 7'h40;
      repeat (16) @(posedge core_clk);
      resetn <= 1'b1;
      test_idle();
      test_run(7'h40, 7'h00, 1'b0);
      data_seed <= 16'hffe0;
      // Second run reads with the falling-edge sample from the third byte
      rx_type2_en <= 1'b1;
      test_run(7'h25, 7'h01, 1'b1);
      give_verdict();
   end
endmodule
